// File: pkg/cpmpt_consts.svh
// Register offsets, field positions and counts for the clock and periodic timer block
`ifndef CPMPT_CONSTS_SVH
`define CPMPT_CONSTS_SVH
`define CPMPT_IDX_PLL 12'h03A
`define CPMPT_IDX_OSC 12'h2FA
`define CPMPT_IDX_TEST2 12'h2FC
`define CPMPT_IDX_PERIODIC_OSC_TRIM 12'h2F0
`define CPMPT_IDX_RATEH 12'h2F2
`define CPMPT_IDX_RATEL 12'h2F3
`define CPMPT_IDX_TEST3 12'h2F4
`define CPMPT_IDX_TEMP_SENSOR_TRIM_BITS 12'h2F5
`define CPMPT_IDX_TRIMH 12'h2F6
`define CPMPT_IDX_TRIML 12'h2F7
`define CPMPT_IDX_REG_WRITE_PROTECT 12'h2FB
`define CPMPT_IDX_CTRL 12'h2E0
`define CPMPT_IDX_STAT 12'h2E1
`define CPMPT_REG_WRITE_PROTECT_KEY 8'h26
`define CPMPT_REG_WRITE_PROTECT_UNLOCK 8'hCF
`define CPMPT_FM_DIV 5'h10
`define CPMPT_CTRL_TEN 0
`define CPMPT_CTRL_CLK 1
`define CPMPT_CTRL_PIE 2
`define CPMPT_CTRL_EA 3
`define CPMPT_CTRL_LIE 4
`define CPMPT_CTRL_HIE 5
`define CPMPT_CTRL_PSEL 6
`define CPMPT_ST_PIF 0
`define CPMPT_ST_LIF 1
`define CPMPT_ST_HIF 2
`define CPMPT_ST_LVS 3
`define CPMPT_ST_HTS 4
`define CPMPT_ST_LOCK 5
`define CPMPT_ST_OSC_UP_FLAG 6
`define CPMPT_RESP_OKAY 2'h0
`define CPMPT_RESP_SLVERR 2'h2
`endif

// File: pkg/cpmpt_pkg.sv
// Types for the clock and periodic timer block
package cpmpt_pkg;
  typedef struct packed {
    logic [1:0] fm_amp;
    logic fm_active;
    logic [4:0] fm_phase;
  } cpmpt_fm_t;
  typedef struct packed {
    logic low_volt_irq;
    logic high_temp_irq;
    logic periodic_irq;
  } cpmpt_irq_t;
  typedef enum logic [1:0] {CPMPT_T_IDLE, CPMPT_T_START, CPMPT_T_RUN} cpmpt_tstate_t;
endpackage : cpmpt_pkg

// File: hdl/cpmpt_top.sv
// Clock control, voltage/temperature monitor and periodic timer with AXI4-Lite registers
`timescale 1ns/1ps
`default_nettype none
`include "cpmpt_consts.svh"
// Function
// - PLL control writes only when unprotected and PLL selected; reads always.
// - Any PLL control write clears lock and oscillator-up status.
// - Modulation amplitude code 00 off, 01 1%, 10 2%, 11 4%.
// - Modulation rate is reference clock divided by sixteen.
// - Factory test register readable always, writable only in special mode.
// - Low-voltage status follows supply comparator in full performance mode.
// - Low-voltage status change sets flag; enable gates the request.
// - High-temperature status follows temperature comparator in full performance mode.
// - High-temperature status change sets flag; enable gates the request.
// - Periodic timer runs only while enabled, independent of system clock.
// - Timer clocked by RC oscillator or bus clock; with bus clock selected it freezes when bus clock stops.
// - Clock-select writable only while timer disabled.
// - Rate field writable only while timer disabled.
// - Timer counts rate period, sets flag, restarts automatically.
// - Flag and interrupt enable raise periodic request.
// - First period after enable may be shorter due to start-up.
// - Timer enable and external access drive waveform on pin.
module cpmpt_top #(
  parameter int START_DELAY = 2
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // AXI4-Lite write
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Analog monitors and clock status
  input wire logic full_perf_mode_i,
  input wire logic supply_low_i,
  input wire logic temp_high_i,
  input wire logic pll_lock_i,
  input wire logic osc_up_i,
  input wire logic special_mode_i,
  input wire logic rc_osc_tick_i,
  input wire logic bus_clock_run_i,
  input wire logic ref_clock_tick_i,
  // Outputs
  output logic low_volt_irq_o,
  output logic high_temp_irq_o,
  output logic periodic_irq_o,
  output logic periodic_wave_pin_o,
  output logic [1:0] fm_amp_o,
  output logic fm_active_o,
  output logic fm_toggle_o
);
  // Pin inputs pass a two-stage synchroniser
  logic [8:0] sync_a;
  logic [8:0] sync_b;
  logic [8:0] sync_b_d;
  wire logic [8:0] raw_in = {ref_clock_tick_i, bus_clock_run_i, rc_osc_tick_i, special_mode_i,
                             osc_up_i, pll_lock_i, temp_high_i, supply_low_i, full_perf_mode_i};
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      sync_a <= 9'h000;
      sync_b <= 9'h000;
      sync_b_d <= 9'h000;
    end else begin
      sync_a <= raw_in;
      sync_b <= sync_a;
      sync_b_d <= sync_b;
    end
  end
  wire logic full_perf_mode = sync_b[0];
  wire logic rc_edge = sync_b[6] & ~sync_b_d[6];
  wire logic bus_run = sync_b[7];
  wire logic ref_edge = sync_b[8] & ~sync_b_d[8];
  wire logic lock_rise = sync_b[3] & ~sync_b_d[3];
  wire logic up_rise = sync_b[4] & ~sync_b_d[4];

  function automatic logic [11:0] word_index(input logic [31:0] a);
    word_index = a[13:2];
  endfunction : word_index

  // Register state
  logic [1:0] fm_amp, next_fm_amp;
  logic [7:0] osc_cfg, next_osc_cfg;
  logic [7:0] test2, next_test2;
  logic [7:0] test3, next_test3;
  logic [5:0] osc_trim, next_osc_trim;
  logic [15:0] rate, next_rate;
  logic [7:0] temp_sensor_trim_bits, next_temp_sensor_trim_bits;
  logic [7:0] trim_h, next_trim_h;
  logic [7:0] trim_l, next_trim_l;
  logic reg_write_protect, next_reg_write_protect;
  logic [6:0] ctrl, next_ctrl;
  logic lvs, next_lvs, hts, next_hts;
  logic lif, next_lif, hif, next_hif, pif, next_pif;
  logic lock_st, next_lock_st, up_st, next_up_st;
  // Bus handshake state
  logic aw_held, next_aw_held, w_held, next_w_held;
  logic [31:0] aw_addr, next_aw_addr, w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0] bresp, next_bresp, rresp, next_rresp;
  logic [31:0] rdata, next_rdata;
  // Ready flags registered so each bus output leaves a flip-flop
  logic aw_rdy, w_rdy, ar_rdy;
  // Timer state
  cpmpt_pkg::cpmpt_tstate_t tstate, next_tstate;
  logic [15:0] tcount, next_tcount;
  logic wave, next_wave;
  cpmpt_pkg::cpmpt_fm_t fm, next_fm;
  cpmpt_pkg::cpmpt_irq_t irq, next_irq;

  wire logic wr_go = aw_held & w_held & ~bvalid;
  wire logic [11:0] wr_idx = word_index(aw_addr);
  wire logic [7:0] wb = w_strb[0] ? w_data[7:0] : 8'h00;
  wire logic wr_lane = w_strb[0];
  wire logic ten = ctrl[`CPMPT_CTRL_TEN];
  // Selected timer clock; bus clock path stalls when the bus clock is stopped
  wire logic tick = ctrl[`CPMPT_CTRL_CLK] ? bus_run : rc_edge;

  always_comb begin
    next_aw_held = aw_held;
    next_w_held = w_held;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = bvalid;
    next_bresp = bresp;
    next_rvalid = rvalid;
    next_rresp = rresp;
    next_rdata = rdata;
    next_fm_amp = fm_amp;
    next_osc_cfg = osc_cfg;
    next_test2 = test2;
    next_test3 = test3;
    next_osc_trim = osc_trim;
    next_rate = rate;
    next_temp_sensor_trim_bits = temp_sensor_trim_bits;
    next_trim_h = trim_h;
    next_trim_l = trim_l;
    next_reg_write_protect = reg_write_protect;
    next_ctrl = ctrl;
    next_lock_st = lock_st | lock_rise;
    next_up_st = up_st | up_rise;
    next_lif = lif;
    next_hif = hif;
    next_pif = pif;
    if (s_axi_awvalid && !aw_held) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (wr_go) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = `CPMPT_RESP_OKAY;
      case (wr_idx)
        `CPMPT_IDX_PLL: begin
          if (wr_lane && !reg_write_protect && ctrl[`CPMPT_CTRL_PSEL]) begin
            next_fm_amp = wb[5:4];
          end
          next_lock_st = 1'b0;
          next_up_st = 1'b0;
        end
        `CPMPT_IDX_OSC: if (wr_lane) next_osc_cfg = wb;
        `CPMPT_IDX_TEST2: if (wr_lane && sync_b[5]) next_test2 = wb;
        `CPMPT_IDX_TEST3: if (wr_lane && sync_b[5]) next_test3 = wb;
        `CPMPT_IDX_PERIODIC_OSC_TRIM: if (wr_lane) next_osc_trim = wb[7:2];
        `CPMPT_IDX_RATEH: if (wr_lane && !ten) next_rate[15:8] = wb;
        `CPMPT_IDX_RATEL: if (wr_lane && !ten) next_rate[7:0] = wb;
        `CPMPT_IDX_TEMP_SENSOR_TRIM_BITS: if (wr_lane) next_temp_sensor_trim_bits = {wb[7], 3'h0, wb[3:0]};
        `CPMPT_IDX_TRIMH: if (wr_lane) next_trim_h = {wb[7:4], 2'h0, wb[1:0]};
        `CPMPT_IDX_TRIML: if (wr_lane) next_trim_l = wb;
        `CPMPT_IDX_REG_WRITE_PROTECT: begin
          if (wr_lane && wb == `CPMPT_REG_WRITE_PROTECT_KEY) next_reg_write_protect = 1'b0;
          else if (wr_lane && wb == `CPMPT_REG_WRITE_PROTECT_UNLOCK) next_reg_write_protect = 1'b0;
          else if (wr_lane) next_reg_write_protect = 1'b1;
        end
        `CPMPT_IDX_CTRL: begin
          if (wr_lane) begin
            next_ctrl = wb[6:0];
            if (ten) next_ctrl[`CPMPT_CTRL_CLK] = ctrl[`CPMPT_CTRL_CLK];
          end
        end
        `CPMPT_IDX_STAT: begin
          if (wr_lane && wb[`CPMPT_ST_PIF]) next_pif = 1'b0;
          if (wr_lane && wb[`CPMPT_ST_LIF]) next_lif = 1'b0;
          if (wr_lane && wb[`CPMPT_ST_HIF]) next_hif = 1'b0;
        end
        default: next_bresp = `CPMPT_RESP_SLVERR;
      endcase
    end
    // Hardware sets after the clear so an event in the clearing cycle survives
    if (next_lvs != lvs) next_lif = 1'b1;
    if (next_hts != hts) next_hif = 1'b1;
    if (tstate == cpmpt_pkg::CPMPT_T_RUN && tick && tcount == 16'h0000) next_pif = 1'b1;
    if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && !rvalid) begin
      next_rvalid = 1'b1;
      next_rresp = `CPMPT_RESP_OKAY;
      next_rdata = 32'h0000_0000;
      case (word_index(s_axi_araddr))
        `CPMPT_IDX_PLL: next_rdata[7:0] = {2'h0, fm_amp, 4'h0};
        `CPMPT_IDX_OSC: next_rdata[7:0] = osc_cfg;
        `CPMPT_IDX_TEST2: next_rdata[7:0] = test2;
        `CPMPT_IDX_TEST3: next_rdata[7:0] = test3;
        `CPMPT_IDX_PERIODIC_OSC_TRIM: next_rdata[7:0] = {osc_trim, 2'h0};
        `CPMPT_IDX_RATEH: next_rdata[7:0] = rate[15:8];
        `CPMPT_IDX_RATEL: next_rdata[7:0] = rate[7:0];
        `CPMPT_IDX_TEMP_SENSOR_TRIM_BITS: next_rdata[7:0] = temp_sensor_trim_bits;
        `CPMPT_IDX_TRIMH: next_rdata[7:0] = trim_h;
        `CPMPT_IDX_TRIML: next_rdata[7:0] = trim_l;
        `CPMPT_IDX_REG_WRITE_PROTECT: next_rdata[7:0] = {7'h00, reg_write_protect};
        `CPMPT_IDX_CTRL: next_rdata[7:0] = {1'b0, ctrl};
        `CPMPT_IDX_STAT: next_rdata[7:0] = {1'b0, up_st, lock_st, hts, lvs, hif, lif, pif};
        default: next_rresp = `CPMPT_RESP_SLVERR;
      endcase
    end
  end

  // Monitors only track in full performance mode; elsewhere they hold
  always_comb begin
    next_lvs = full_perf_mode ? sync_b[1] : lvs;
    next_hts = full_perf_mode ? sync_b[2] : hts;
  end

  // Periodic timer; start-up stage shortens the first period
  always_comb begin
    next_tstate = tstate;
    next_tcount = tcount;
    next_wave = wave;
    case (tstate)
      cpmpt_pkg::CPMPT_T_IDLE: begin
        next_wave = 1'b0;
        if (ten) begin
          next_tstate = cpmpt_pkg::CPMPT_T_START;
          next_tcount = 16'(START_DELAY);
        end
      end
      cpmpt_pkg::CPMPT_T_START: begin
        if (!ten) next_tstate = cpmpt_pkg::CPMPT_T_IDLE;
        else if (tick) begin
          next_tstate = cpmpt_pkg::CPMPT_T_RUN;
          next_tcount = (rate > 16'(START_DELAY)) ? rate - 16'(START_DELAY) : 16'h0000;
        end
      end
      cpmpt_pkg::CPMPT_T_RUN: begin
        if (!ten) next_tstate = cpmpt_pkg::CPMPT_T_IDLE;
        else if (tick) begin
          if (tcount == 16'h0000) begin
            next_tcount = rate;
            next_wave = ~wave;
          end else begin
            next_tcount = tcount - 16'h0001;
          end
        end
      end
      default: next_tstate = cpmpt_pkg::CPMPT_T_IDLE;
    endcase
  end

  // Modulation sequencer at reference over sixteen
  always_comb begin
    next_fm.fm_amp = fm_amp;
    next_fm.fm_active = fm_amp != 2'h0;
    next_fm.fm_phase = fm.fm_phase;
    if (next_fm.fm_active && ref_edge) begin
      next_fm.fm_phase = (fm.fm_phase == `CPMPT_FM_DIV - 5'h01) ? 5'h00 : fm.fm_phase + 5'h01;
    end
    if (!next_fm.fm_active) next_fm.fm_phase = 5'h00;
    next_irq.low_volt_irq = lif & ctrl[`CPMPT_CTRL_LIE];
    next_irq.high_temp_irq = hif & ctrl[`CPMPT_CTRL_HIE];
    next_irq.periodic_irq = pif & ctrl[`CPMPT_CTRL_PIE];
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 32'h0000_0000;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      rvalid <= 1'b0;
      rresp <= 2'h0;
      rdata <= 32'h0000_0000;
      fm_amp <= 2'h0;
      osc_cfg <= 8'h00;
      test2 <= 8'h00;
      test3 <= 8'h00;
      osc_trim <= 6'h00;
      rate <= 16'h0000;
      temp_sensor_trim_bits <= 8'h00;
      trim_h <= 8'h00;
      trim_l <= 8'h00;
      reg_write_protect <= 1'b0;
      ctrl <= 7'h00;
      lvs <= 1'b0;
      hts <= 1'b0;
      lif <= 1'b0;
      hif <= 1'b0;
      pif <= 1'b0;
      lock_st <= 1'b0;
      up_st <= 1'b0;
      tstate <= cpmpt_pkg::CPMPT_T_IDLE;
      tcount <= 16'h0000;
      wave <= 1'b0;
      fm <= '0;
      irq <= '0;
      periodic_wave_pin_o <= 1'b0;
      aw_rdy <= 1'b1;
      w_rdy <= 1'b1;
      ar_rdy <= 1'b1;
    end else begin
      aw_held <= next_aw_held;
      w_held <= next_w_held;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bvalid <= next_bvalid;
      bresp <= next_bresp;
      rvalid <= next_rvalid;
      rresp <= next_rresp;
      rdata <= next_rdata;
      fm_amp <= next_fm_amp;
      osc_cfg <= next_osc_cfg;
      test2 <= next_test2;
      test3 <= next_test3;
      osc_trim <= next_osc_trim;
      rate <= next_rate;
      temp_sensor_trim_bits <= next_temp_sensor_trim_bits;
      trim_h <= next_trim_h;
      trim_l <= next_trim_l;
      reg_write_protect <= next_reg_write_protect;
      ctrl <= next_ctrl;
      lvs <= next_lvs;
      hts <= next_hts;
      lif <= next_lif;
      hif <= next_hif;
      pif <= next_pif;
      lock_st <= next_lock_st;
      up_st <= next_up_st;
      tstate <= next_tstate;
      tcount <= next_tcount;
      wave <= next_wave;
      fm <= next_fm;
      irq <= next_irq;
      periodic_wave_pin_o <= next_wave & ctrl[`CPMPT_CTRL_EA] & ten;
      aw_rdy <= ~next_aw_held;
      w_rdy <= ~next_w_held;
      ar_rdy <= ~next_rvalid;
    end
  end

  assign s_axi_awready = aw_rdy;
  assign s_axi_wready = w_rdy;
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_arready = ar_rdy;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rresp = rresp;
  assign s_axi_rdata = rdata;
  assign low_volt_irq_o = irq.low_volt_irq;
  assign high_temp_irq_o = irq.high_temp_irq;
  assign periodic_irq_o = irq.periodic_irq;
  assign fm_amp_o = fm.fm_amp;
  assign fm_active_o = fm.fm_active;
  assign fm_toggle_o = fm.fm_phase[3];
endmodule : cpmpt_top
`default_nettype wire

// File: dv/cpmpt_checker.sv
// Bus and output checks for the clock and periodic timer block
`timescale 1ns/1ps
`default_nettype none
`include "cpmpt_consts.svh"
module cpmpt_checker #(
  parameter int START_DELAY = 2
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic reset_i,
  // Register bus
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Outputs
  input wire logic low_volt_irq_o,
  input wire logic high_temp_irq_o,
  input wire logic periodic_irq_o,
  input wire logic [1:0] fm_amp_o,
  input wire logic fm_active_o
);
  logic unmapped;
  assign unmapped = s_axi_araddr[31:14] == 18'h0 && s_axi_araddr[1:0] == 2'h0 &&
    !(s_axi_araddr[13:2] inside {`CPMPT_IDX_PLL, `CPMPT_IDX_OSC, `CPMPT_IDX_TEST2,
    `CPMPT_IDX_PERIODIC_OSC_TRIM, `CPMPT_IDX_RATEH, `CPMPT_IDX_RATEL, `CPMPT_IDX_TEST3, `CPMPT_IDX_TEMP_SENSOR_TRIM_BITS,
    `CPMPT_IDX_TRIMH, `CPMPT_IDX_TRIML, `CPMPT_IDX_REG_WRITE_PROTECT, `CPMPT_IDX_CTRL, `CPMPT_IDX_STAT});
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read answer missing");
  a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write answer missing");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_read_refused: assert property (s_rd_taken and unmapped |=> s_axi_rresp == `CPMPT_RESP_SLVERR)
    else $error("unmapped read not refused");
  a_fm_active: assert property (fm_active_o == (fm_amp_o != 2'h0))
    else $error("modulation active flag wrong");
  a_quiet_reset: assert property (disable iff (1'b0) reset_i |=> !low_volt_irq_o && !high_temp_irq_o
    && !periodic_irq_o) else $error("request during reset");
endmodule : cpmpt_checker
bind cpmpt_top cpmpt_checker #(.START_DELAY(START_DELAY)) u_checker (.clock_i, .reset_i,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .low_volt_irq_o, .high_temp_irq_o, .periodic_irq_o, .fm_amp_o,
  .fm_active_o);
`default_nettype wire

// File: dv/cpmpt_tb_top.sv
// Self-checking bench for the clock and periodic timer block
`timescale 1ns/1ps
`default_nettype none
`include "cpmpt_consts.svh"
module cpmpt_tb_top;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0, s_axi_rdata;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0] s_axi_wstrb = 4'h1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, fm_amp, mon = 2'h0;
  logic full_perf_mode = 1'b0, lock = 1'b0, oup = 1'b0, spec = 1'b0, brun = 1'b1;
  logic lv_irq, ht_irq, p_irq, wave, fm_act, fm_tog;
  logic [7:0] tcnt = 8'h0;
  logic [31:0] rs = 32'h57;
  logic [1:0] exp_b[$];
  logic [33:0] exp_r[$];
  int bad_count = 0;
  int check_count = 0;
  always #20 clock_i = ~clock_i;
  // Reference and RC ticks from one counter keep their rates exact
  always @(posedge clock_i) tcnt <= tcnt + 8'h01;
  cpmpt_top #(.START_DELAY(2)) dut (.clock_i, .reset_i, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .full_perf_mode_i(full_perf_mode), .supply_low_i(mon[0]),
    .temp_high_i(mon[1]), .pll_lock_i(lock), .osc_up_i(oup), .special_mode_i(spec),
    .rc_osc_tick_i(tcnt[2]), .bus_clock_run_i(brun), .ref_clock_tick_i(tcnt[1]),
    .low_volt_irq_o(lv_irq), .high_temp_irq_o(ht_irq), .periodic_irq_o(p_irq),
    .periodic_wave_pin_o(wave), .fm_amp_o(fm_amp), .fm_active_o(fm_act), .fm_toggle_o(fm_tog));
  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd
  function automatic logic pick(input int s);
    logic [4:0] v;
    v = {fm_tog, wave, p_irq, ht_irq, lv_irq};
    return v[s];
  endfunction : pick
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  task automatic cmp_reg(input string nm, input logic [33:0] e, input logic [33:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_reg
  task automatic cmp_pin(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_reg(nm, {18'h0, e}, {18'h0, g});
  endtask : cmp_pin
  task automatic stuck(input int n);
    if (n >= 3000) begin
      bad_count++;
      $display("CHECK FAILED wait expected done seen timeout");
      complete_run();
    end
  endtask : stuck
  task automatic wr(input logic [11:0] i, input logic [7:0] d, input logic [1:0] r = 2'h0,
                    input logic [3:0] st = 4'h1);
    int n;
    exp_b.push_back(r);
    s_axi_awaddr <= {18'h0, i, 2'h0};
    s_axi_wstrb <= st;
    s_axi_wdata <= {rnd() & 32'hFFFFFF00} | d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 3000 && (s_axi_awvalid || s_axi_wvalid || !s_axi_bvalid); n++) begin
      @(posedge clock_i);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end
    stuck(n);
    s_axi_bready <= 1'b0;
    @(posedge clock_i);
  endtask : wr
  task automatic rd(input logic [11:0] i, input logic [7:0] e, input logic [1:0] r = 2'h0);
    int n;
    exp_r.push_back({r, 24'h0, e});
    s_axi_araddr <= {18'h0, i, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 3000 && (s_axi_arvalid || !s_axi_rvalid); n++) begin
      @(posedge clock_i);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end
    stuck(n);
    s_axi_rready <= 1'b0;
    @(posedge clock_i);
  endtask : rd
  always @(posedge clock_i) begin
    if (s_axi_bvalid && s_axi_bready) cmp_reg("bresp", {32'h0, exp_b.pop_front()}, {32'h0, s_axi_bresp});
    if (s_axi_rvalid && s_axi_rready) cmp_reg("read", exp_r.pop_front(), {s_axi_rresp, s_axi_rdata});
  end
  task automatic wait_pin(input int s, input logic v);
    int n;
    for (n = 0; n < 3000 && pick(s) !== v; n++) @(posedge clock_i);
    stuck(n);
  endtask : wait_pin
  // A negative level means the pin must only keep its starting value
  task automatic hold_pin(input int s, input int c, input int e = -1);
    logic v;
    v = pick(s);
    repeat (c) @(posedge clock_i);
    cmp_pin("steady pin", 16'((e < 0) ? v : e), pick(s));
  endtask : hold_pin
  // Counts cycles between two changes; the first change may come from a short period
  task automatic measure(input int s, input int e);
    logic v;
    int n;
    int c;
    v = pick(s);
    for (n = 0; n < 3000 && pick(s) === v; n++) @(posedge clock_i);
    stuck(n);
    v = pick(s);
    c = 0;
    for (n = 0; n < 3000 && pick(s) === v; n++) begin
      @(posedge clock_i);
      c++;
    end
    stuck(n);
    cmp_pin("period", e, c);
  endtask : measure
  initial begin
    int k;
    logic [7:0] d;
    repeat (6) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    rd(`CPMPT_IDX_PLL, 8'h00);
    wr(`CPMPT_IDX_PLL, 8'h30);
    rd(`CPMPT_IDX_PLL, 8'h00);
    wr(`CPMPT_IDX_CTRL, 8'h40);
    for (k = 0; k < 4; k++) begin
      wr(`CPMPT_IDX_PLL, 8'(k << 4));
      rd(`CPMPT_IDX_PLL, 8'(k << 4));
      cmp_pin("fm_amp", 16'(k), {14'h0, fm_amp});
      cmp_pin("fm_active", 16'(k != 0), {15'h0, fm_act});
    end
    measure(4, 32);
    wr(`CPMPT_IDX_REG_WRITE_PROTECT, 8'h11);
    wr(`CPMPT_IDX_PLL, 8'h10);
    rd(`CPMPT_IDX_PLL, 8'h30);
    wr(`CPMPT_IDX_REG_WRITE_PROTECT, `CPMPT_REG_WRITE_PROTECT_UNLOCK);
    lock <= 1'b1;
    oup <= 1'b1;
    repeat (8) @(posedge clock_i);
    rd(`CPMPT_IDX_STAT, 8'h60);
    wr(`CPMPT_IDX_PLL, 8'h00);
    rd(`CPMPT_IDX_STAT, 8'h00);
    for (k = 0; k < 3; k++) begin
      d = 8'(rnd());
      wr(`CPMPT_IDX_TRIML, d);
      rd(`CPMPT_IDX_TRIML, d);
    end
    wr(`CPMPT_IDX_TRIML, ~d, 2'h0, 4'hE);
    rd(`CPMPT_IDX_TRIML, d);
    wr(`CPMPT_IDX_OSC, 8'hC0);
    rd(`CPMPT_IDX_OSC, 8'hC0);
    wr(`CPMPT_IDX_PERIODIC_OSC_TRIM, 8'hA7);
    rd(`CPMPT_IDX_PERIODIC_OSC_TRIM, 8'hA4);
    wr(12'h100, 8'h5A, `CPMPT_RESP_SLVERR);
    rd(12'h100, 8'h00, `CPMPT_RESP_SLVERR);
    spec <= 1'b1;
    repeat (4) @(posedge clock_i);
    wr(`CPMPT_IDX_TEST2, 8'hA5);
    rd(`CPMPT_IDX_TEST2, 8'hA5);
    spec <= 1'b0;
    repeat (4) @(posedge clock_i);
    wr(`CPMPT_IDX_TEST2, 8'hFF);
    rd(`CPMPT_IDX_TEST2, 8'hA5);
    mon <= 2'h1;
    repeat (8) @(posedge clock_i);
    rd(`CPMPT_IDX_STAT, 8'h00);
    mon <= 2'h0;
    repeat (4) @(posedge clock_i);
    full_perf_mode <= 1'b1;
    repeat (4) @(posedge clock_i);
    for (k = 0; k < 2; k++) begin
      wr(`CPMPT_IDX_CTRL, 8'h40 | (8'h10 << k));
      mon[k] <= 1'b1;
      wait_pin(k, 1'b1);
      rd(`CPMPT_IDX_STAT, 8'h0A << k);
      wr(`CPMPT_IDX_STAT, 8'h00);
      rd(`CPMPT_IDX_STAT, 8'h0A << k);
      wr(`CPMPT_IDX_STAT, 8'h02 << k);
      wait_pin(k, 1'b0);
      wr(`CPMPT_IDX_CTRL, 8'h40);
      mon[k] <= 1'b0;
      hold_pin(k, 8, 0);
      rd(`CPMPT_IDX_STAT, 8'h02 << k);
      wr(`CPMPT_IDX_STAT, 8'h02 << k);
    end
    k = 3 + int'(rnd() & 32'h7);
    wr(`CPMPT_IDX_RATEH, 8'h00);
    wr(`CPMPT_IDX_RATEL, 8'(k));
    wr(`CPMPT_IDX_CTRL, 8'h4E);
    wr(`CPMPT_IDX_CTRL, 8'h4F);
    measure(3, k + 1);
    measure(3, k + 1);
    wait_pin(2, 1'b1);
    wr(`CPMPT_IDX_RATEL, 8'hFF);
    rd(`CPMPT_IDX_RATEL, 8'(k));
    wr(`CPMPT_IDX_CTRL, 8'h4D);
    rd(`CPMPT_IDX_CTRL, 8'h4F);
    measure(3, k + 1);
    brun <= 1'b0;
    repeat (4) @(posedge clock_i);
    hold_pin(3, 40);
    brun <= 1'b1;
    wr(`CPMPT_IDX_CTRL, 8'h4C);
    wr(`CPMPT_IDX_STAT, 8'h01);
    hold_pin(2, 40, 0);
    hold_pin(3, 40, 0);
    wr(`CPMPT_IDX_CTRL, 8'h4D);
    measure(3, (k + 1) * 8);
    wr(`CPMPT_IDX_CTRL, 8'h45);
    hold_pin(3, 200, 0);
    complete_run();
  end
endmodule : cpmpt_tb_top
`default_nettype wire
